// ===== rtl/alu_cfg.svh
/*
  Constants for the add-and-shift datapath: register offsets, status bit
  positions, reset values and the addresses of the indirect access slots.
  Assumes inclusion by bare name from the design files.
*/
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// Register byte offsets on the register bus
`define OFS_ACCUMULATOR    12'h000
`define OFS_STATUS         12'h004
`define OFS_POINTER0       12'h008
`define OFS_POINTER1       12'h00C

// Status register bit positions
`define BIT_CARRY          0
`define BIT_DIGIT_CARRY    1
`define BIT_ZERO           2
`define BIT_BUSY           3

// Reset values
`define RST_ACCUMULATOR    8'h00
`define RST_POINTER        16'h0000
`define RST_FLAG           1'b0

// File addresses of the indirect access register slots
`define ADDR_INDIRECT0     7'h00
`define ADDR_INDIRECT1     7'h01

// Top bit of an indirect pointer pair
`define BIT_POINTER_TOP    15

`endif

// ===== rtl/alu_pkg.sv
/*
  Types for the add-and-shift datapath: operation codes handed over by the
  instruction decoder and the sequencer states.
  Assumes nothing of its surroundings.
*/
package alu_pkg;

  typedef enum logic [2:0] {
    OP_ADD_LITERAL_TO_POINTER,
    OP_AND_IMMEDIATE_TO_ACCUMULATOR,
    OP_ADD_IMMEDIATE_TO_ACCUMULATOR,
    OP_AND_ACCUMULATOR_WITH_FILE,
    OP_ADD_ACCUMULATOR_WITH_FILE,
    OP_ARITHMETIC_SHIFT_RIGHT_FILE,
    OP_ADD_ACCUMULATOR_FILE_CARRY
  } op_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_LATCH,
    ST_STALL,
    ST_EXEC
  } state_t;

endpackage

// ===== rtl/alu_add_flags.sv
/*
  Eight-bit adder with carry in, giving sum, carry out of bit 7, carry out
  of bit 3 and zero. Purely combinational; operands come from flip-flops
  of the instantiating datapath.
*/
`timescale 1ns/100ps
`default_nettype none

module alu_add_flags (
  input  wire logic [7:0] addA,
  input  wire logic [7:0] addB,
  input  wire logic       carryIn,
  output logic      [7:0] sum,
  output logic            carryOut,
  output logic            digitCarryOut,
  output logic            zero
);

  logic [8:0] fullSum;
  logic [4:0] lowSum;

  assign fullSum       = {1'b0, addA} + {1'b0, addB} + {8'h00, carryIn};
  assign lowSum        = {1'b0, addA[3:0]} + {1'b0, addB[3:0]}
                         + {4'h0, carryIn};
  assign sum           = fullSum[7:0];
  assign carryOut      = fullSum[8];
  assign digitCarryOut = lowSum[4];
  assign zero          = (fullSum[7:0] == 8'h00);

endmodule

`default_nettype wire

// ===== rtl/mcu_add_and_shift_datapath.sv
/*
  Execution datapath for add, AND, add-with-carry, arithmetic right shift
  and pointer-add operations of a small 8-bit core, with an APB slave for
  the accumulator, status flags and the two indirect pointer pairs.
  Assumes a decoder on ref_clk handing over decoded operations and a data
  memory with one-cycle registered read and single-cycle write.
*/
// Functional notes
// - Pointer add: sign-extend 6-bit literal, add to pointer 0 or 1.
// - Pointer pair is 16-bit modular; results wrap, never saturate.
// - AND immediate into accumulator; only zero flag changes.
// - Add immediate into accumulator; carry, digit carry, zero change.
// - AND accumulator with file register; only zero flag changes.
// - Add accumulator and file register; carry, digit carry, zero change.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Shift file right, keep bit 7, old bit 0 to carry; carry, zero.
// - Add accumulator, file and carry; route by destination; three flags.
// - File operand is a 7-bit address, locations 0 to 127.
// - Indirect slot with pointer top bit set costs one extra cycle.
`timescale 1ns/100ps
`default_nettype none
`include "alu_cfg.svh"

module mcu_add_and_shift_datapath (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          opValid,
  output logic               opReady,
  input  wire alu_pkg::op_t  opCode,
  input  wire logic [7:0]    opLiteral,
  input  wire logic [6:0]    opFileAddr,
  input  wire logic          opDestFile,
  input  wire logic          opPtrSel,
  output logic               opDone,
  output logic               memRdEn,
  output logic      [6:0]    memAddr,
  input  wire logic [7:0]    memRdData,
  output logic               memWrEn,
  output logic      [7:0]    memWrData
);

  alu_pkg::state_t state_ff;
  alu_pkg::state_t nxt_state;
  alu_pkg::op_t    op_ff;
  alu_pkg::op_t    nxt_op;
  logic [7:0]      lit_ff;
  logic [7:0]      nxt_lit;
  logic [6:0]      addr_ff;
  logic [6:0]      nxt_addr;
  logic            destFile_ff;
  logic            nxt_destFile;
  logic            ptrSel_ff;
  logic            nxt_ptrSel;
  logic [7:0]      opnd_ff;
  logic [7:0]      nxt_opnd;
  logic [7:0]      acc_ff;
  logic [7:0]      nxt_acc;
  logic            carry_ff;
  logic            nxt_carry;
  logic            digitCarry_ff;
  logic            nxt_digitCarry;
  logic            zero_ff;
  logic            nxt_zero;
  logic [15:0]     ptr0_ff;
  logic [15:0]     nxt_ptr0;
  logic [15:0]     ptr1_ff;
  logic [15:0]     nxt_ptr1;
  logic            memWrEn_ff;
  logic            nxt_memWrEn;
  logic [7:0]      memWrData_ff;
  logic [7:0]      nxt_memWrData;
  logic            done_ff;
  logic            nxt_done;
  logic [31:0]     prdata_ff;
  logic [31:0]     nxt_prdata;

  logic [7:0]      addB;
  logic            addCarryIn;
  logic [7:0]      addSum;
  logic            addCarry;
  logic            addDigitCarry;
  logic            addZero;
  logic [7:0]      result;
  logic [15:0]     ptrStep;
  logic            apbWrite;
  logic            indirectPenalty;

  function automatic logic isFileOp(input alu_pkg::op_t op);
    isFileOp = (op == alu_pkg::OP_AND_ACCUMULATOR_WITH_FILE)
            || (op == alu_pkg::OP_ADD_ACCUMULATOR_WITH_FILE)
            || (op == alu_pkg::OP_ARITHMETIC_SHIFT_RIGHT_FILE)
            || (op == alu_pkg::OP_ADD_ACCUMULATOR_FILE_CARRY);
  endfunction

  function automatic logic isMapped(input logic [11:0] addr);
    isMapped = (addr == `OFS_ACCUMULATOR) || (addr == `OFS_STATUS)
            || (addr == `OFS_POINTER0) || (addr == `OFS_POINTER1);
  endfunction

  // Shared adder for the accumulator add forms; pointer add uses its own adder
  alu_add_flags u_add (
    .addA          (acc_ff),
    .addB          (addB),
    .carryIn       (addCarryIn),
    .sum           (addSum),
    .carryOut      (addCarry),
    .digitCarryOut (addDigitCarry),
    .zero          (addZero)
  );

  assign addB       = (op_ff == alu_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR)
                      ? lit_ff : opnd_ff;
  assign addCarryIn = (op_ff == alu_pkg::OP_ADD_ACCUMULATOR_FILE_CARRY)
                      && carry_ff;
  assign ptrStep    = {{10{lit_ff[5]}}, lit_ff[5:0]};

  // indirect slot with pointer top bit set
  assign indirectPenalty =
      ((addr_ff == `ADDR_INDIRECT0) && ptr0_ff[`BIT_POINTER_TOP])
   || ((addr_ff == `ADDR_INDIRECT1) && ptr1_ff[`BIT_POINTER_TOP]);

  assign apbWrite  = psel && penable && pwrite;
  assign pready    = psel && penable;
  assign pslverr   = psel && penable && !isMapped(paddr);
  assign prdata    = prdata_ff;
  assign opReady   = (state_ff == alu_pkg::ST_IDLE);
  assign opDone    = done_ff;
  assign memRdEn   = (state_ff == alu_pkg::ST_READ);
  assign memAddr   = addr_ff;
  assign memWrEn   = memWrEn_ff;
  assign memWrData = memWrData_ff;

  always_comb begin
    nxt_state      = state_ff;
    nxt_op         = op_ff;
    nxt_lit        = lit_ff;
    nxt_addr       = addr_ff;
    nxt_destFile   = destFile_ff;
    nxt_ptrSel     = ptrSel_ff;
    nxt_opnd       = opnd_ff;
    nxt_acc        = acc_ff;
    nxt_carry      = carry_ff;
    nxt_digitCarry = digitCarry_ff;
    nxt_zero       = zero_ff;
    nxt_ptr0       = ptr0_ff;
    nxt_ptr1       = ptr1_ff;
    nxt_memWrEn    = 1'b0;
    nxt_memWrData  = memWrData_ff;
    nxt_done       = 1'b0;
    nxt_prdata     = prdata_ff;
    result         = 8'h00;

    // Read data is captured in the setup phase
    if (psel && !penable) begin
      nxt_prdata = 32'h0000_0000;
      if (paddr == `OFS_ACCUMULATOR) begin
        nxt_prdata[7:0] = acc_ff;
      end else if (paddr == `OFS_STATUS) begin
        nxt_prdata[`BIT_CARRY]       = carry_ff;
        nxt_prdata[`BIT_DIGIT_CARRY] = digitCarry_ff;
        nxt_prdata[`BIT_ZERO]        = zero_ff;
        nxt_prdata[`BIT_BUSY]        = (state_ff != alu_pkg::ST_IDLE);
      end else if (paddr == `OFS_POINTER0) begin
        nxt_prdata[15:0] = ptr0_ff;
      end else if (paddr == `OFS_POINTER1) begin
        nxt_prdata[15:0] = ptr1_ff;
      end
    end

    // Software writes; the datapath below overrides in the same cycle
    if (apbWrite) begin
      if (paddr == `OFS_ACCUMULATOR) begin
        nxt_acc = pwdata[7:0];
      end else if (paddr == `OFS_STATUS) begin
        nxt_carry      = pwdata[`BIT_CARRY];
        nxt_digitCarry = pwdata[`BIT_DIGIT_CARRY];
        nxt_zero       = pwdata[`BIT_ZERO];
      end else if (paddr == `OFS_POINTER0) begin
        nxt_ptr0 = pwdata[15:0];
      end else if (paddr == `OFS_POINTER1) begin
        nxt_ptr1 = pwdata[15:0];
      end
    end

    unique case (state_ff)
      alu_pkg::ST_IDLE: begin
        if (opValid) begin
          nxt_op       = opCode;
          nxt_lit      = opLiteral;
          nxt_addr     = opFileAddr;
          nxt_destFile = opDestFile;
          nxt_ptrSel   = opPtrSel;
          nxt_state    = isFileOp(opCode) ? alu_pkg::ST_READ
                                          : alu_pkg::ST_EXEC;
        end
      end
      alu_pkg::ST_READ: begin
        nxt_state = alu_pkg::ST_LATCH;
      end
      alu_pkg::ST_LATCH: begin
        nxt_opnd = memRdData;
        nxt_state = indirectPenalty ? alu_pkg::ST_STALL : alu_pkg::ST_EXEC;
      end
      alu_pkg::ST_STALL: begin
        nxt_state = alu_pkg::ST_EXEC;
      end
      alu_pkg::ST_EXEC: begin
        nxt_state = alu_pkg::ST_IDLE;
        nxt_done  = 1'b1;
        unique case (op_ff)
          alu_pkg::OP_ADD_LITERAL_TO_POINTER: begin
            if (ptrSel_ff) begin
              nxt_ptr1 = ptr1_ff + ptrStep;
            end else begin
              nxt_ptr0 = ptr0_ff + ptrStep;
            end
          end
          alu_pkg::OP_AND_IMMEDIATE_TO_ACCUMULATOR: begin
            result   = acc_ff & lit_ff;
            nxt_zero = (result == 8'h00);
          end
          alu_pkg::OP_AND_ACCUMULATOR_WITH_FILE: begin
            result   = acc_ff & opnd_ff;
            nxt_zero = (result == 8'h00);
          end
          alu_pkg::OP_ARITHMETIC_SHIFT_RIGHT_FILE: begin
            result    = {opnd_ff[7], opnd_ff[7:1]};
            nxt_carry = opnd_ff[0];
            nxt_zero  = (result == 8'h00);
          end
          default: begin
            result         = addSum;
            nxt_carry      = addCarry;
            nxt_digitCarry = addDigitCarry;
            nxt_zero       = addZero;
          end
        endcase
        if (op_ff != alu_pkg::OP_ADD_LITERAL_TO_POINTER) begin
          if (isFileOp(op_ff) && destFile_ff) begin
            nxt_memWrEn   = 1'b1;
            nxt_memWrData = result;
          end else begin
            nxt_acc = result;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff      <= alu_pkg::ST_IDLE;
      op_ff         <= alu_pkg::OP_ADD_LITERAL_TO_POINTER;
      lit_ff        <= 8'h00;
      addr_ff       <= 7'h00;
      destFile_ff   <= 1'b0;
      ptrSel_ff     <= 1'b0;
      opnd_ff       <= 8'h00;
      acc_ff        <= `RST_ACCUMULATOR;
      carry_ff      <= `RST_FLAG;
      digitCarry_ff <= `RST_FLAG;
      zero_ff       <= `RST_FLAG;
      ptr0_ff       <= `RST_POINTER;
      ptr1_ff       <= `RST_POINTER;
      memWrEn_ff    <= 1'b0;
      memWrData_ff  <= 8'h00;
      done_ff       <= 1'b0;
      prdata_ff     <= 32'h0000_0000;
    end else begin
      state_ff      <= nxt_state;
      op_ff         <= nxt_op;
      lit_ff        <= nxt_lit;
      addr_ff       <= nxt_addr;
      destFile_ff   <= nxt_destFile;
      ptrSel_ff     <= nxt_ptrSel;
      opnd_ff       <= nxt_opnd;
      acc_ff        <= nxt_acc;
      carry_ff      <= nxt_carry;
      digitCarry_ff <= nxt_digitCarry;
      zero_ff       <= nxt_zero;
      ptr0_ff       <= nxt_ptr0;
      ptr1_ff       <= nxt_ptr1;
      memWrEn_ff    <= nxt_memWrEn;
      memWrData_ff  <= nxt_memWrData;
      done_ff       <= nxt_done;
      prdata_ff     <= nxt_prdata;
    end
  end

endmodule

`default_nettype wire

// ===== dv/add_shift_memory_model.sv
/*
  Data memory behind the datapath file port.
  Assumes one-cycle registered read and write on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module add_shift_memory_model (
  input  wire logic       ref_clk,
  input  wire logic       memRdEn,
  input  wire logic [6:0] memAddr,
  input  wire logic       memWrEn,
  input  wire logic [7:0] memWrData,
  output logic      [7:0] memRdData
);
  logic [7:0] store [128];
  initial begin
    for (int i = 0; i < 128; i++) store[i] = 8'(i * 59 + 17);
  end
  always @(posedge ref_clk) begin
    if (memWrEn) store[memAddr] <= memWrData;
    // Valid one cycle, then scrambled
    memRdData <= memRdEn ? store[memAddr] : ~memRdData;
  end
endmodule
`default_nettype wire

// ===== dv/mcu_add_and_shift_datapath_properties.sv
/*
  Port checker for the datapath operation and memory ports.
  Assumes binding to the datapath top module.
*/
`timescale 1ns/100ps
`default_nettype none
module mcu_add_and_shift_datapath_properties (
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         opValid,
  input wire logic         opReady,
  input wire alu_pkg::op_t opCode,
  input wire logic [6:0]   opFileAddr,
  input wire logic         opDestFile,
  input wire logic         opDone,
  input wire logic         memRdEn,
  input wire logic [6:0]   memAddr,
  input wire logic         memWrEn,
  input wire logic [7:0]   memWrData
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic take;
  logic fileOp;
  assign take = opValid && opReady;
  assign fileOp = opCode > alu_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR;
  property p_lit_done; take && !fileOp |-> ##2 opDone; endproperty
  a_lit_done: assert property (p_lit_done)
    else $error("Literal op not retired in time");
  property p_lit_nomem; take && !fileOp |=> !memRdEn [*2]; endproperty
  a_lit_nomem: assert property (p_lit_nomem)
    else $error("Literal op touched memory");
  property p_file_read;
    take && fileOp |=> memRdEn && memAddr == $past(opFileAddr);
  endproperty
  a_file_read: assert property (p_file_read)
    else $error("File read address wrong");
  property p_file_done; take && fileOp |-> ##[4:5] opDone; endproperty
  a_file_done: assert property (p_file_done)
    else $error("File op not retired in time");
  property p_acc_dest;
    take && fileOp && !opDestFile |=> !memWrEn [*5];
  endproperty
  a_acc_dest: assert property (p_acc_dest)
    else $error("Accumulator destination wrote memory");
  property p_file_dest;
    take && fileOp && opDestFile |-> ##[4:5] (opDone && memWrEn);
  endproperty
  a_file_dest: assert property (p_file_dest)
    else $error("File destination not written");
  property p_wr_done; memWrEn |-> opDone; endproperty
  a_wr_done: assert property (p_wr_done)
    else $error("Memory write outside retire");
  property p_asr_msb;
    take && opCode == alu_pkg::OP_ARITHMETIC_SHIFT_RIGHT_FILE && opDestFile
      |-> ##[4:5] (memWrEn && memWrData[7] == memWrData[6]);
  endproperty
  a_asr_msb: assert property (p_asr_msb)
    else $error("Shift lost the top bit");
  c_file_wr: cover property (take && fileOp && opDestFile);
  c_ptr_add: cover property (take && opCode == 3'h0);
  c_stall: cover property (take && fileOp ##5 opDone);
endmodule
bind mcu_add_and_shift_datapath mcu_add_and_shift_datapath_properties
  chk_u (.ref_clk, .rst, .opValid, .opReady, .opCode, .opFileAddr,
  .opDestFile, .opDone, .memRdEn, .memAddr, .memWrEn, .memWrData);
`default_nettype wire

// ===== dv/test_mcu_add_and_shift_datapath.sv
/*
  Self-checking bench for the add-and-shift datapath.
  Assumes the memory model and the bound port checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "alu_cfg.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin \
  numErrors++; $display("Error %s expected %h seen %h", nm, (e), (g)); end end
module test_mcu_add_and_shift_datapath;
  logic         ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic         pready, pslverr, opValid = 0, opReady, opDestFile = 0;
  logic         opPtrSel = 0, opDone, memRdEn, memWrEn;
  alu_pkg::op_t opCode = alu_pkg::OP_ADD_LITERAL_TO_POINTER;
  logic [7:0]   opLiteral = 8'h00, memRdData, memWrData, r1;
  logic [6:0]   opFileAddr = 7'h00, memAddr;
  logic [7:0]   acc = 8'h00, seed = 8'h4C, mirror [128];
  logic [15:0]  ptr [2];
  logic         c = 0, dc = 0, z = 0;
  int           numErrors = 0, numChecks = 0, cycles = 0;
  mcu_add_and_shift_datapath dut_u (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .opValid,
    .opReady, .opCode, .opLiteral, .opFileAddr, .opDestFile, .opPtrSel,
    .opDone, .memRdEn, .memAddr, .memRdData, .memWrEn, .memWrData);
  add_shift_memory_model mem_u (.ref_clk, .memRdEn, .memAddr, .memWrEn,
    .memWrData, .memRdData);
  always #2 ref_clk = ~ref_clk;
  task automatic tallyAndFinish();
    if (numErrors == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors++;
      tallyAndFinish();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [9:0] addF(input logic [7:0] a, b,
      input logic ci);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {t[8], h[4], t[7:0]};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1 && cycles < 20000);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic chkRd(input logic [11:0] a, input logic [31:0] e,
      input string nm);
    logic [31:0] d;
    logic er;
    apb(1'b0, a, 32'h0, d, er);
    `CHK(nm, e, d)
    `CHK("pslverr", 1'b0, er)
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, d, x, er);
  endtask
  task automatic runOp(input alu_pkg::op_t op, input logic [7:0] k,
      input logic [6:0] fa, input logic dst, input logic ps);
    logic [9:0] s;
    logic [7:0] f;
    logic fOp, slow;
    int n;
    f = mirror[fa];
    fOp = op > alu_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR;
    slow = (fa == 7'h00 && ptr[0][15]) || (fa == 7'h01 && ptr[1][15]);
    s = {c, dc, acc};
    case (op)
      alu_pkg::OP_ADD_LITERAL_TO_POINTER:
        ptr[ps] = ptr[ps] + {{10{k[5]}}, k[5:0]};
      alu_pkg::OP_AND_IMMEDIATE_TO_ACCUMULATOR: s[7:0] = acc & k;
      alu_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR: s = addF(acc, k, 1'b0);
      alu_pkg::OP_AND_ACCUMULATOR_WITH_FILE: s[7:0] = acc & f;
      alu_pkg::OP_ADD_ACCUMULATOR_WITH_FILE: s = addF(acc, f, 1'b0);
      alu_pkg::OP_ARITHMETIC_SHIFT_RIGHT_FILE: s = {f[0], dc, f[7], f[7:1]};
      default: s = addF(acc, f, c);
    endcase
    if (op != alu_pkg::OP_ADD_LITERAL_TO_POINTER) begin
      {c, dc} = s[9:8];
      z = s[7:0] == 8'h00;
    end
    if (fOp && dst) mirror[fa] = s[7:0];
    else if (op != alu_pkg::OP_ADD_LITERAL_TO_POINTER) acc = s[7:0];
    @(posedge ref_clk);
    opValid <= 1;
    opCode <= op;
    {opLiteral, opFileAddr, opDestFile, opPtrSel} <= {k, fa, dst, ps};
    @(posedge ref_clk);
    `CHK("opReady", 1'b1, opReady)
    opValid <= 0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (opDone !== 1'b1 && n < 20);
    `CHK("cycles", fOp ? 4 + int'(slow) : 2, n)
    `CHK("memWrEn", fOp && dst, memWrEn)
    if (fOp && dst) `CHK("memWrData", s[7:0], memWrData)
    chkRd(`OFS_ACCUMULATOR, {24'h0, acc}, "acc");
    chkRd(`OFS_STATUS, {29'h0, z, dc, c}, "status");
    chkRd(ps ? `OFS_POINTER1 : `OFS_POINTER0, {16'h0, ptr[ps]},
      "ptr");
  endtask
  initial begin
    logic [31:0] d;
    logic er;
    for (int i = 0; i < 128; i++) mirror[i] = 8'(i * 59 + 17);
    ptr[0] = 16'h0000;
    ptr[1] = 16'h0000;
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) chkRd(12'(i * 4), 32'h0, "reset");
    apb(1'b0, 12'h010, 32'h0, d, er);
    `CHK("pslverr", 1'b1, er)
    `CHK("unmapped", 32'h0, d)
    wr(`OFS_STATUS, 32'h5);
    {z, dc, c} = 3'b101;
    chkRd(`OFS_STATUS, 32'h5, "status rw");
    wr(`OFS_POINTER0, 32'hFFF0);
    wr(`OFS_POINTER1, 32'h0005);
    wr(`OFS_ACCUMULATOR, 32'hFF);
    {ptr[0], ptr[1], acc} = {16'hFFF0, 16'h0005, 8'hFF};
    runOp(alu_pkg::OP_ADD_LITERAL_TO_POINTER, 8'h1F, 7'h00,
      1'b0, 1'b0);
    runOp(alu_pkg::OP_ADD_LITERAL_TO_POINTER, 8'h20, 7'h00,
      1'b0, 1'b1);
    runOp(alu_pkg::OP_ADD_IMMEDIATE_TO_ACCUMULATOR, 8'h01, 7'h00,
      1'b0, 1'b0);
    runOp(alu_pkg::OP_ARITHMETIC_SHIFT_RIGHT_FILE, 8'h00, 7'h7F,
      1'b1, 1'b0);
    runOp(alu_pkg::OP_ADD_ACCUMULATOR_FILE_CARRY, 8'h00, 7'h01,
      1'b1, 1'b0);
    repeat (90) begin
      seed = lfsr(seed);
      r1 = seed;
      seed = lfsr(seed);
      runOp(alu_pkg::op_t'(3'(r1 % 7)), seed,
        r1[7] ? 7'(seed[0]) : seed[6:0], r1[3], seed[7]);
    end
    tallyAndFinish();
  end
endmodule
`default_nettype wire
